//--- design/iop_map.vh
`ifndef IOP_MAP_VH
`define IOP_MAP_VH
// ----------------------------------------------------------------------
// register offsets (byte addresses, word index times four)
// ----------------------------------------------------------------------
`define IOP_IDX_P4_DATA 16'hFFD7
`define IOP_IDX_P4_DIR 16'hFFE7
`define IOP_ADR_P4_DATA 18'h3FF5C
`define IOP_ADR_P4_DIR 18'h3FF9C
`define IOP_ADR_P3_MODE 18'h00000
`define IOP_ADR_P3_DIR 18'h00004
`define IOP_ADR_P3_PULLUP 18'h00008
`define IOP_ADR_SER2_CTRL 18'h0000C
`define IOP_ADR_OP_MODE 18'h00010
`define IOP_ADR_P3_PINS 18'h00014
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IOP_RST_P4_DATA 8'hF8
`define IOP_RST_P4_DIR 8'hF8
`define IOP_RST_ZERO 8'h00
`define IOP_RST_MODE 3'h1
// ----------------------------------------------------------------------
// port-3 mode select bits
// ----------------------------------------------------------------------
`define IOP_P3M_PWM 0
`define IOP_P3M_UPDN 1
`define IOP_P3M_RESET_OUTPUT 2
// ----------------------------------------------------------------------
// serial2 control bits
// ----------------------------------------------------------------------
`define IOP_S2_TE 0
`define IOP_S2_INV 1
`define IOP_S2_GP 2
// ----------------------------------------------------------------------
// operating mode codes
// ----------------------------------------------------------------------
`define IOP_OM_ACTIVE 3'h0
`define IOP_OM_SUBACTIVE 3'h1
`define IOP_OM_SLEEP 3'h2
`define IOP_OM_SUBSLEEP 3'h3
`define IOP_OM_WATCH 3'h4
`define IOP_OM_STANDBY 3'h5
`endif

//--- design/iop_port_ctrl.v
// Chosen here: register access over Wishbone.
`include "iop_map.vh"
module iop_port_ctrl
(
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] sel_i,
   input wire [17:0] adr_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   input wire [7:0] port3_pin_i,
   output reg [7:0] port3_out_o,
   output reg [7:0] port3_oe_o,
   output reg [7:0] port3_pullup_o,
   output reg port3_count_direction_o,
   input wire pwm_i,
   input wire reset_output_i,
   input wire [3:0] port4_pin_i,
   output reg [2:0] port4_out_o,
   output reg [2:0] port4_oe_o,
   input wire serial2_tx_out_i,
   input wire serial2_rx_sel_i,
   input wire serial2_clk_oe_i,
   input wire serial2_clk_out_i,
   input wire serial2_clk_sel_i
);
   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [2:0] port3_mode_select_reg;
   reg [7:0] port3_direction_reg;
   reg [7:0] port3_pullup_enable_reg;
   reg [7:0] port3_data_reg;
   reg [2:0] port4_data_reg;
   reg [2:0] port4_direction_reg;
   reg [2:0] serial2_control_reg;
   reg [2:0] op_mode_reg;
   reg [7:0] port3_out_next;
   reg [7:0] port3_oe_next;
   reg [7:0] port3_pullup_next;
   reg [2:0] port4_out_next;
   reg [2:0] port4_oe_next;
   reg [7:0] port4_read;
   reg [31:0] rd_next;
   wire take;
   wire wr;
   wire [7:0] wbyte;
   wire standby;
   wire retain;
   wire tx_sel;
   integer i;
   integer j;
   // reset words are full bytes; only the three latch bits are stored
   wire [7:0] p4_data_rst = `IOP_RST_P4_DATA;
   wire [7:0] p4_dir_rst = `IOP_RST_P4_DIR;

   // ----------------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------------
   iop_wb_slave u_slave
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .ack_o(ack_o),
      .take_o(take)
   );

   // writes need lane 0, where every register sits
   assign wr = take & we_i & sel_i[0];
   assign wbyte = dat_i[7:0];

   // address compare, used by both write and read paths
   function hit;
      input [17:0] a;
      input [17:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port3_mode_select_reg <= 3'h0;
         port3_direction_reg <= `IOP_RST_ZERO;
         port3_pullup_enable_reg <= `IOP_RST_ZERO;
         port3_data_reg <= `IOP_RST_ZERO;
         port4_data_reg <= p4_data_rst[2:0];
         port4_direction_reg <= p4_dir_rst[2:0];
         serial2_control_reg <= 3'h0;
         op_mode_reg <= `IOP_RST_MODE;
      end
      else if (wr)
      begin
         if (hit(adr_i, `IOP_ADR_P3_MODE))
            port3_mode_select_reg <= wbyte[2:0];
         if (hit(adr_i, `IOP_ADR_P3_DIR))
            port3_direction_reg <= wbyte;
         if (hit(adr_i, `IOP_ADR_P3_PULLUP))
            port3_pullup_enable_reg <= wbyte;
         if (hit(adr_i, `IOP_ADR_P3_PINS))
            port3_data_reg <= wbyte;
         // upper bits are fixed; only the three latches store
         if (hit(adr_i, `IOP_ADR_P4_DATA))
            port4_data_reg <= wbyte[2:0];
         if (hit(adr_i, `IOP_ADR_P4_DIR))
            port4_direction_reg <= wbyte[2:0];
         if (hit(adr_i, `IOP_ADR_SER2_CTRL))
            serial2_control_reg <= wbyte[2:0];
         if (hit(adr_i, `IOP_ADR_OP_MODE))
            op_mode_reg <= wbyte[2:0];
      end
   end

   // ----------------------------------------------------------------------
   // port 4 read value
   // ----------------------------------------------------------------------
   always @*
   begin
      port4_read = 8'hF0;
      port4_read[3] = port4_pin_i[3];
      for (i = 0; i < 3; i = i + 1)
      begin
         if (port4_direction_reg[i])
            port4_read[i] = port4_data_reg[i];
         else
            port4_read[i] = port4_pin_i[i];
      end
   end

   // ----------------------------------------------------------------------
   // read mux, unmapped words read zero
   // ----------------------------------------------------------------------
   always @*
   begin
      rd_next = 32'h00000000;
      if (hit(adr_i, `IOP_ADR_P4_DATA))
         rd_next[7:0] = port4_read;
      else if (hit(adr_i, `IOP_ADR_P4_DIR))
         rd_next[7:0] = 8'hFF;
      else if (hit(adr_i, `IOP_ADR_P3_MODE))
         rd_next[2:0] = port3_mode_select_reg;
      else if (hit(adr_i, `IOP_ADR_P3_DIR))
         rd_next[7:0] = port3_direction_reg;
      else if (hit(adr_i, `IOP_ADR_P3_PULLUP))
         rd_next[7:0] = port3_pullup_enable_reg;
      else if (hit(adr_i, `IOP_ADR_SER2_CTRL))
         rd_next[2:0] = serial2_control_reg;
      else if (hit(adr_i, `IOP_ADR_OP_MODE))
         rd_next[2:0] = op_mode_reg;
      else if (hit(adr_i, `IOP_ADR_P3_PINS))
         rd_next[7:0] = port3_pin_i;
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h00000000;
      else if (take)
         dat_o <= rd_next;
   end

   // ----------------------------------------------------------------------
   // operating mode decode
   // ----------------------------------------------------------------------
   assign standby = (op_mode_reg == `IOP_OM_STANDBY);
   assign retain = (op_mode_reg == `IOP_OM_SLEEP) |
                   (op_mode_reg == `IOP_OM_SUBSLEEP) |
                   (op_mode_reg == `IOP_OM_WATCH);
   // transmit enable alone hands pin over; invert bit only flips the driven data
   assign tx_sel = serial2_control_reg[`IOP_S2_TE];

   // ----------------------------------------------------------------------
   // port 3 pin drive
   // ----------------------------------------------------------------------
   always @*
   begin
      port3_out_next = port3_data_reg;
      port3_oe_next = port3_direction_reg;
      for (j = 0; j < 8; j = j + 1)
         port3_pullup_next[j] = ~port3_direction_reg[j] &
                                port3_pullup_enable_reg[j];
      if (port3_mode_select_reg[`IOP_P3M_PWM])
      begin
         port3_out_next[0] = pwm_i;
         port3_oe_next[0] = 1'b1;
      end
      if (port3_mode_select_reg[`IOP_P3M_UPDN])
      begin
         port3_oe_next[1] = 1'b0;
      end
      if (port3_mode_select_reg[`IOP_P3M_RESET_OUTPUT])
      begin
         port3_out_next[2] = reset_output_i;
         port3_oe_next[2] = 1'b1;
      end
      // upper pins: hold in sleep, subsleep and watch, float in standby unless pulled up
      if (retain)
      begin
         port3_out_next[7:3] = port3_out_o[7:3];
         port3_oe_next[7:3] = port3_oe_o[7:3];
      end
      else if (standby)
      begin
         port3_oe_next[7:3] = port3_pullup_next[7:3];
         port3_out_next[7:3] = 5'h1F;
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port3_out_o <= 8'h00;
         port3_oe_o <= 8'h00;
         port3_pullup_o <= 8'h00;
         port3_count_direction_o <= 1'b0;
      end
      else
      begin
         port3_out_o <= port3_out_next;
         port3_oe_o <= port3_oe_next;
         port3_pullup_o <= port3_pullup_next;
         port3_count_direction_o <=
            port3_mode_select_reg[`IOP_P3M_UPDN] & port3_pin_i[1];
      end
   end

   // ----------------------------------------------------------------------
   // port 4 pin drive
   // ----------------------------------------------------------------------
   always @*
   begin
      port4_out_next = port4_data_reg;
      port4_oe_next = port4_direction_reg;
      if (!serial2_control_reg[`IOP_S2_GP])
      begin
         // serial function owns pins 1 and 0
         port4_oe_next[1:0] = {1'b0, serial2_clk_oe_i};
         port4_out_next[1:0] = {1'b0, serial2_clk_out_i};
      end
      if (tx_sel)
      begin
         port4_oe_next[2] = 1'b1;
         port4_out_next[2] = serial2_tx_out_i ^
                             serial2_control_reg[`IOP_S2_INV];
      end
      if (standby)
         port4_oe_next = 3'h0;
      else if (retain)
      begin
         port4_oe_next = port4_oe_o;
         port4_out_next = port4_out_o;
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port4_out_o <= 3'h0;
         port4_oe_o <= 3'h0;
      end
      else
      begin
         port4_out_o <= port4_out_next;
         port4_oe_o <= port4_oe_next;
      end
   end
endmodule

//--- design/iop_wb_slave.v
`include "iop_map.vh"
// ----------------------------------------------------------------------
// classic wishbone handshake: one wait state, ack for one cycle
// ----------------------------------------------------------------------
module iop_wb_slave
(
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   output reg ack_o,
   output wire take_o
);
   // take once per request; ack drop lets the master release first
   assign take_o = cyc_i & stb_i & ~ack_o;

   always @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= take_o;
   end
endmodule

//--- verification/iop_port_ctrl_props.sv
`include "iop_map.vh"
module iop_port_ctrl_props
(
   input logic clk_i,
   input logic rst_i,
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic [3:0] sel_i,
   input logic [17:0] adr_i,
   input logic [31:0] dat_i,
   input logic [31:0] dat_o,
   input logic ack_o,
   input logic [7:0] port3_pin_i,
   input logic [7:0] port3_out_o,
   input logic [7:0] port3_oe_o,
   input logic [7:0] port3_pullup_o,
   input logic port3_count_direction_o,
   input logic pwm_i,
   input logic reset_output_i,
   input logic [2:0] port4_out_o,
   input logic [2:0] port4_oe_o,
   input logic serial2_tx_out_i,
   input logic serial2_clk_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [2:0] mode_reg;
   reg [2:0] ser_reg;
   // ---------------------------------------------
   // shadow words, written at the ack edge
   // ---------------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_reg <= 3'h0;
         ser_reg <= 3'h0;
      end
      else if (ack_o && we_i && sel_i[0])
      begin
         if (adr_i == `IOP_ADR_P3_MODE)
            mode_reg <= dat_i[2:0];
         if (adr_i == `IOP_ADR_SER2_CTRL)
            ser_reg <= dat_i[2:0];
      end
   end
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // a read taken at one edge and answered at the next
   sequence rd_at(a);
      cyc_i && stb_i && !ack_o && !we_i && adr_i == a ##1 ack_o;
   endsequence
   chk_ack_one: assert property (cyc_i && stb_i && !ack_o |=>
      ack_o ##1 !ack_o) else $error("ack not one cycle");
   chk_dir_ones: assert property (rd_at(`IOP_ADR_P4_DIR) |->
      dat_o == 32'hFF) else $error("p4 dir read");
   chk_data_top: assert property (rd_at(`IOP_ADR_P4_DATA) |->
      dat_o[31:4] == 28'hF) else $error("p4 data top");
   // reset is the cause here, so it must not mask itself
   chk_reset_idle: assert property (disable iff (1'b0)
      rst_i |=> !port3_oe_o && !port4_oe_o && !port3_pullup_o)
      else $error("pins not idle in reset");
   chk_pwm_route: assert property (mode_reg[0] && $past(mode_reg[0])
      |-> port3_oe_o[0] && port3_out_o[0] == $past(pwm_i))
      else $error("pwm route");
   chk_reset_output_route: assert property (mode_reg[2] && $past(mode_reg[2])
      |-> port3_oe_o[2] && port3_out_o[2] == $past(reset_output_i))
      else $error("reset out route");
   chk_count_in: assert property ($stable(mode_reg[1]) |->
      port3_count_direction_o == (mode_reg[1] & $past(port3_pin_i[1])))
      else $error("count input");
   chk_tx_route: assert property (ser_reg[0] && $past(ser_reg[0]) |->
      port4_oe_o[2] && port4_out_o[2] == ($past(serial2_tx_out_i) ^
      ser_reg[1])) else $error("tx route");
   chk_serial_clk: assert property (!ser_reg[2] && !$past(ser_reg[2])
      |-> port4_oe_o[0] == $past(serial2_clk_oe_i))
      else $error("serial clk oe");
endmodule
bind iop_port_ctrl iop_port_ctrl_props u_props (.*);

//--- verification/iop_port_ctrl_test.sv
`include "iop_map.vh"
module iop_port_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pwm_i, reset_output_i;
   logic serial2_tx_out_i, serial2_rx_sel_i, serial2_clk_oe_i;
   logic serial2_clk_out_i, serial2_clk_sel_i, port3_count_direction_o;
   logic [3:0] sel_i, port4_pin_i;
   logic [17:0] adr_i;
   logic [31:0] dat_i, dat_o, q;
   logic [7:0] port3_pin_i, port3_out_o, port3_oe_o, port3_pullup_o;
   logic [2:0] port4_out_o, port4_oe_o;
   int n_fail = 0;
   int cmp_count = 0;
   int p4l, p4d, p3d, p3u, e;
   iop_port_ctrl uut (.*);
   // 4 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ---------------------------------------------
   // compare, bus cycles, verdict
   // ---------------------------------------------
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // request held until ack is seen high at an edge
   task automatic wb(input logic w, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
      // look at ack where it has settled, take data before its edge
      for (n = 0; n < 20; n++)
      begin
         @(negedge clk_i);
         if (ack_o === 1'b1)
            break;
      end
      if (n >= 20)
      begin
         n_fail++;
         wrap_up;
      end
      q = dat_o;
      @(posedge clk_i);
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task automatic wr(input logic [17:0] a, input int d);
      wb(1'b1, a, 32'(d), 4'hF);
   endtask
   // fresh state after any reset
   task automatic rst_chk;
      rst_i <= 1'b0;
      port4_pin_i <= 4'h8;
      wb(1'b0, `IOP_ADR_P4_DATA, 0, 4'hF);
      chk("p4 data", q, 32'hF8);
      wb(1'b0, `IOP_ADR_P4_DIR, 0, 4'hF);
      chk("p4 dir", q, 32'hFF);
      chk("pullup", port3_pullup_o, 0);
   endtask
   initial
   begin
      {cyc_i, stb_i, we_i, pwm_i, reset_output_i, serial2_tx_out_i} = '0;
      {serial2_rx_sel_i, serial2_clk_oe_i, serial2_clk_out_i} = '0;
      serial2_clk_sel_i = 1'b0;
      {sel_i, adr_i, dat_i, port3_pin_i, port4_pin_i} = '0;
      rst_i = 1'b1;
      void'($urandom(32'hEFEB));
      repeat (10) @(posedge clk_i);
      rst_chk;
      // unmapped place: write dropped, read zero
      wr(18'h00100, 'hFF);
      wb(1'b0, 18'h00100, 0, 4'hF);
      chk("unmapped", q, 0);
      // serial owns pins 1,0 until general use is chosen
      repeat (8)
      begin
         @(posedge clk_i);
         {serial2_clk_oe_i, serial2_clk_out_i} <= 2'($urandom);
      end
      serial2_clk_oe_i <= 1'b0;
      wr(`IOP_ADR_SER2_CTRL, 4);
      for (int i = 0; i < 8; i++)
      begin
         {p4d, p4l} = {$urandom & 7, $urandom & 7};
         port4_pin_i <= 4'($urandom);
         wr(`IOP_ADR_P4_DIR, p4d);
         wr(`IOP_ADR_P4_DATA, p4l);
         wb(1'b1, `IOP_ADR_P4_DATA, 32'h7, 4'hE);
         wb(1'b0, `IOP_ADR_P4_DATA, 0, 4'hF);
         e = 'hF0 | port4_pin_i[3] << 3 | p4d & p4l | ~p4d & port4_pin_i;
         chk("p4 read", q, e);
         chk("p4 oe", port4_oe_o, p4d);
         chk("p4 out", port4_out_o & p4d, p4l & p4d);
      end
      // tx data on pin 2, plain then inverted
      for (int i = 0; i < 8; i++)
      begin
         if (i % 4 == 0)
            wr(`IOP_ADR_SER2_CTRL, 5 | i / 4 << 1);
         serial2_tx_out_i <= 1'($urandom);
         repeat (3) @(posedge clk_i);
         chk("tx pin", port4_out_o[2], serial2_tx_out_i ^ i / 4);
      end
      wr(`IOP_ADR_SER2_CTRL, 4);
      // every mode combination with random directions and pull-ups
      for (int i = 0; i < 8; i++)
      begin
         {p3d, p3u} = {$urandom & 'hFF, $urandom & 'hFF};
         {pwm_i, reset_output_i, port3_pin_i} <= 10'($urandom);
         wr(`IOP_ADR_P3_MODE, i);
         wr(`IOP_ADR_P3_DIR, p3d);
         wr(`IOP_ADR_P3_PULLUP, p3u);
         repeat (2) @(posedge clk_i);
         e = (p3d | i & 5) & ~(i & 2);
         chk("p3 oe", port3_oe_o, e);
         chk("p3 pullup", port3_pullup_o, ~p3d & p3u & 'hFF);
      end
      // standby: pulled-up upper pins drive high, the other upper pins float
      wr(`IOP_ADR_P3_MODE, 0);
      // sleep: upper pins keep their drive while direction changes
      wr(`IOP_ADR_OP_MODE, 2);
      wr(`IOP_ADR_P3_DIR, ~p3d & 'hFF);
      repeat (2) @(posedge clk_i);
      chk("sleep oe", port3_oe_o & 'hF8, p3d & 'hF8);
      wr(`IOP_ADR_P3_DIR, p3d);
      wr(`IOP_ADR_OP_MODE, 5);
      repeat (2) @(posedge clk_i);
      e = ~p3d & p3u & 'hF8;
      chk("standby oe", port3_oe_o & 'hF8, e);
      chk("standby out", port3_out_o & e, e);
      wr(`IOP_ADR_OP_MODE, 0);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_chk;
      wrap_up;
   end
endmodule
